// ### core/fsr_status_read.sv
// Two-byte status register with serial read-status command
`timescale 1ns/1ps
module fsr_status_read (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic wp_n,
    input fsr_pkg::fsr_live_t live,
    input fsr_pkg::fsr_write_t wr,
    output logic so_out,
    output logic so_oe,
    output logic [7:0] status_byte_one,
    output logic [7:0] status_byte_two
);
    logic [2:0] pin_sync;
    logic cs_n_s;
    logic sclk_s;
    logic si_s;
    logic wp_n_s;
    logic sclk_prev_reg;
    logic rise;
    logic fall;
    fsr_pkg::fsr_state_t state_reg;
    logic [2:0] bit_reg;
    logic [2:0] out_bit_reg;
    logic wp_sel_s;
    logic [7:0] opc_reg;
    logic byte_sel_reg;
    logic [7:0] shift_reg;
    logic protection_lock_reg;
    logic rst_cmd_allow_reg;
    logic lockdown_cmd_allow_reg;
    logic [7:0] first_byte;
    logic [7:0] second_byte;

    // Serial pins come from the host's domain; select is inverted so
    // the cleared synchroniser reads as deselected after reset
    fsr_sync #(
        .WIDTH(3)
    ) u_sync_link (
        .mclk(mclk),
        .rst(rst),
        .async_in({!cs_n, sclk, si}),
        .sync_out(pin_sync)
    );

    fsr_sync #(
        .WIDTH(1)
    ) u_sync_wp (
        .mclk(mclk),
        .rst(rst),
        .async_in(!wp_n),
        .sync_out(wp_sel_s)
    );

    // Pin levels restored to their own sense
    assign wp_n_s = !wp_sel_s;
    assign cs_n_s = !pin_sync[2];
    assign sclk_s = pin_sync[1];
    assign si_s = pin_sync[0];

    // Edge finding on the synchronised serial clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    assign rise = sclk_s && !sclk_prev_reg && !cs_n_s;
    assign fall = !sclk_s && sclk_prev_reg && !cs_n_s;

    // Assemble byte one from live inputs and the lock bit
    function automatic logic [7:0] make_one(
        input fsr_pkg::fsr_live_t lv,
        input logic lock,
        input logic wp_deasserted
    );
        logic [7:0] b;
        b = fsr_pkg::BYTE_ZERO;
        // R07 lock bit
        b[fsr_pkg::BIT_LOCK] = lock;
        // R09 error flag
        b[fsr_pkg::BIT_ERR] = lv.program_error_flag;
        // R10 pin guard state
        b[fsr_pkg::BIT_PIN] = wp_deasserted;
        // R11 protection summary
        b[fsr_pkg::BIT_SWP_HI] = lv.sw_guard_summary[1];
        b[fsr_pkg::BIT_SWP_LO] = lv.sw_guard_summary[0];
        // R12 write latch
        b[fsr_pkg::BIT_WEL] = lv.write_latch_on;
        // R13 busy flag
        b[fsr_pkg::BIT_BUSY] = lv.busy_flag;
        return b;
    endfunction

    // Assemble byte two; upper bits stay zero
    function automatic logic [7:0] make_two(
        input fsr_pkg::fsr_live_t lv,
        input logic rst_cmd_allow,
        input logic lockdown_cmd_allow
    );
        logic [7:0] b;
        // R08 reserved bits zero
        b = fsr_pkg::BYTE_ZERO;
        // R15 reset command allow
        b[fsr_pkg::BIT_RST_CMD_ALLOW] = rst_cmd_allow;
        // R16 lockdown allow
        b[fsr_pkg::BIT_SLE] = lockdown_cmd_allow;
        // R17 suspend flags
        b[fsr_pkg::BIT_PSUS] = lv.program_paused;
        b[fsr_pkg::BIT_ESUS] = lv.erase_paused;
        // R13 busy in both bytes
        b[fsr_pkg::BIT_BUSY] = lv.busy_flag;
        return b;
    endfunction

    // Pin guard reads 1 while the pin is deasserted (wp_n high)
    assign first_byte = make_one(live, protection_lock_reg, wp_n_s);
    assign second_byte = make_two(live, rst_cmd_allow_reg,
        lockdown_cmd_allow_reg);

    // R14 write byte one, lock bit only
    always_ff @(posedge mclk) begin
        if (rst) begin
            protection_lock_reg <= 1'b0;
        end else if (wr.wr_one) begin
            // Pin asserted: lock may only be set, never cleared
            if (wp_n_s || wr.data[fsr_pkg::BIT_LOCK]) begin
                protection_lock_reg <= wr.data[fsr_pkg::BIT_LOCK];
            end
        end
    end

    // R18 write byte two, bits 4 and 3
    always_ff @(posedge mclk) begin
        if (rst) begin
            rst_cmd_allow_reg <= 1'b0;
            lockdown_cmd_allow_reg <= 1'b0;
        end else if (wr.wr_two) begin
            rst_cmd_allow_reg <= wr.data[fsr_pkg::BIT_RST_CMD_ALLOW];
            lockdown_cmd_allow_reg <= wr.data[fsr_pkg::BIT_SLE];
        end
    end

    // Mirror of both bytes for the rest of the device
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_byte_one <= fsr_pkg::BYTE_ZERO;
            status_byte_two <= fsr_pkg::BYTE_ZERO;
        end else begin
            status_byte_one <= first_byte;
            status_byte_two <= second_byte;
        end
    end

    // Command sequencer; opcode sampled on rising edges
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= fsr_pkg::FSR_IDLE;
            bit_reg <= fsr_pkg::BIT_COUNT_FIRST;
            opc_reg <= fsr_pkg::BYTE_ZERO;
        end else if (cs_n_s) begin
            // R06 deselect ends the read
            state_reg <= fsr_pkg::FSR_IDLE;
            bit_reg <= fsr_pkg::BIT_COUNT_FIRST;
        end else begin
            unique case (state_reg)
                fsr_pkg::FSR_IDLE: begin
                    state_reg <= fsr_pkg::FSR_OPCODE;
                    bit_reg <= fsr_pkg::BIT_COUNT_FIRST;
                end
                fsr_pkg::FSR_OPCODE: begin
                    if (rise) begin
                        opc_reg <= {opc_reg[6:0], si_s};
                        bit_reg <= bit_reg + 3'h1;
                        // R03 no busy check on entry
                        if (bit_reg == fsr_pkg::BIT_COUNT_LAST) begin
                            // R01 match read-status opcode
                            state_reg <= ({opc_reg[6:0], si_s} ==
                                fsr_pkg::OPC_READ_STATUS) ?
                                fsr_pkg::FSR_SEND : fsr_pkg::FSR_IGNORE;
                        end
                    end
                end
                fsr_pkg::FSR_SEND: begin
                    state_reg <= fsr_pkg::FSR_SEND;
                end
                fsr_pkg::FSR_IGNORE: begin
                    state_reg <= fsr_pkg::FSR_IGNORE;
                end
            endcase
        end
    end

    // Output shifter; shifts on falling edges (mode 0 and 3)
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_reg <= fsr_pkg::BYTE_ZERO;
            byte_sel_reg <= 1'b0;
            so_out <= 1'b0;
        end else if (state_reg != fsr_pkg::FSR_SEND) begin
            byte_sel_reg <= 1'b0;
            shift_reg <= first_byte;
            so_out <= 1'b0;
        end else if (fall) begin
            if (out_bit_reg == fsr_pkg::BIT_COUNT_FIRST) begin
                // R04 fresh sample per byte
                // R20 msb first, byte one first
                so_out <= byte_sel_reg ? second_byte[7] : first_byte[7];
                shift_reg <= byte_sel_reg ?
                    {second_byte[6:0], 1'b0} : {first_byte[6:0], 1'b0};
                // R02 alternate bytes forever
                byte_sel_reg <= !byte_sel_reg;
            end else begin
                so_out <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
            end
        end
    end

    // Bit counter for the data phase
    // R05 no special handling; host discards early bytes
    always_ff @(posedge mclk) begin
        if (rst || state_reg != fsr_pkg::FSR_SEND) begin
            out_bit_reg <= fsr_pkg::BIT_COUNT_FIRST;
        end else if (fall) begin
            out_bit_reg <= out_bit_reg + 3'h1;
        end
    end

    // R06 output enable only during the data phase
    always_ff @(posedge mclk) begin
        if (rst) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= (state_reg == fsr_pkg::FSR_SEND) && !cs_n_s;
        end
    end
endmodule

// ### core/fsr_pkg.sv
// Constants and types shared by the flash status register read block
// Operation
// R01: Opcode 05h then status bits every clock
// R02: After byte two, restart at byte one
// R03: Read status accepted even while busy
// R04: Each byte carries freshly sampled status
// R05: Fast clocks: first two bytes invalid
// R06: Chip select release ends read, output floats
// R07: Byte one bit 7 is writable lock
// R08: Reserved bits always read zero
// R09: Byte one bit 5 is error flag
// R10: Bit 4 reads zero while pin asserted
// R11: Bits 3:2 give software protection summary
// R12: Byte one bit 1 is write latch
// R13: Bit 0 of each byte is busy
// R14: Byte one write changes only bit 7
// R15: Byte two bit 4 allows reset command
// R16: Byte two bit 3 allows lockdown commands
// R17: Byte two bits 2,1 are suspend flags
// R18: Byte two write changes bits 4,3 only
// R19: Host polls until busy falls to zero
// R20: Most significant bit first, byte one first
package fsr_pkg;
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;
    localparam int BIT_LOCK = 7;
    localparam int BIT_ERR = 5;
    localparam int BIT_PIN = 4;
    localparam int BIT_SWP_HI = 3;
    localparam int BIT_SWP_LO = 2;
    localparam int BIT_WEL = 1;
    localparam int BIT_BUSY = 0;
    localparam int BIT_RST_CMD_ALLOW = 4;
    localparam int BIT_SLE = 3;
    localparam int BIT_PSUS = 2;
    localparam int BIT_ESUS = 1;
    localparam logic [1:0] SWP_DEFAULT = 2'h3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
    localparam logic [2:0] BIT_COUNT_FIRST = 3'h0;

    // Live status inputs from the rest of the device
    typedef struct packed {
        logic program_error_flag;
        logic wp_asserted;
        logic [1:0] sw_guard_summary;
        logic write_latch_on;
        logic busy_flag;
        logic program_paused;
        logic erase_paused;
    } fsr_live_t;

    // Write strobes for the two writable bytes
    typedef struct packed {
        logic wr_one;
        logic wr_two;
        logic [7:0] data;
    } fsr_write_t;

    typedef enum logic [1:0] {
        FSR_IDLE,
        FSR_OPCODE,
        FSR_SEND,
        FSR_IGNORE
    } fsr_state_t;
endpackage

// ### core/fsr_sync.sv
// Two flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module fsr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ### testbench/fsr_status_read_chk.sv
// Port assertions for the status read block
`timescale 1ns/1ps
module fsr_status_read_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input fsr_pkg::fsr_live_t live,
    input fsr_pkg::fsr_write_t wr,
    input wire logic so_oe,
    input wire logic [7:0] status_byte_one,
    input wire logic [7:0] status_byte_two
);
    // Images follow live status one edge later
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    rsv_zero_a: assert property (
        {status_byte_one[6], status_byte_two[7:5]} == 4'h0)
        else $error("reserved bit set");
    err_track_a: assert property (
        !$past(rst) |->
        status_byte_one[5] == $past(live.program_error_flag))
        else $error("error flag wrong");
    guard_track_a: assert property (
        !$past(rst) |->
        status_byte_one[3:2] == $past(live.sw_guard_summary))
        else $error("guard summary wrong");
    busy_track_a: assert property (
        !$past(rst) |-> {status_byte_one[0], status_byte_two[0]} ==
        {2{$past(live.busy_flag)}})
        else $error("busy bit wrong");
    pause_track_a: assert property (
        !$past(rst) |-> status_byte_two[2:1] ==
        $past({live.program_paused, live.erase_paused}))
        else $error("suspend flags wrong");
    lock_hold_a: assert property (
        !wr.wr_one && !$past(wr.wr_one) && !$past(wr.wr_one, 2) |=>
        $stable(status_byte_one[7]))
        else $error("lock changed unasked");
    two_hold_a: assert property (
        !wr.wr_two && !$past(wr.wr_two) && !$past(wr.wr_two, 2) |=>
        $stable(status_byte_two[4:3]))
        else $error("byte two bits changed");
    cs_off_a: assert property (cs_n [*6] |-> !so_oe)
        else $error("output driven while deselected");
endmodule

bind fsr_status_read fsr_status_read_chk chk_u (.mclk(mclk), .rst(rst),
    .cs_n(cs_n), .live(live), .wr(wr), .so_oe(so_oe),
    .status_byte_one(status_byte_one), .status_byte_two(status_byte_two));

// ### testbench/fsr_host.sv
// Serial host model framing status reads
`timescale 1ns/1ps
module fsr_host (
    input wire logic mclk,
    input wire logic so_out,
    input wire logic so_oe,
    output logic cs_n = 1'h1,
    output logic sclk = 1'h0,
    output logic si = 1'h0
);
    // mode 0 frame, 80 ns clock only inside frames
    task automatic xfer(input logic [7:0] op, input int nbits,
            output logic [31:0] rx, output logic oe);
        rx = 32'h0;
        oe = 1'h0;
        cs_n = 1'h0;
        for (int i = 0; i < 8 + nbits; i++) begin
            sclk = 1'h0;
            // Data line is not ours after the opcode, so keep it moving
            si = (i < 8) ? op[7 - i] : ~si;
            repeat (4) @(negedge mclk);
            sclk = 1'h1;
            repeat (4) @(negedge mclk);
            // Late sample: the device updates a few cycles after each fall
            if (i >= 8) begin
                rx = {rx[30:0], so_out};
                oe = oe | so_oe;
            end
        end
        sclk = 1'h0;
        repeat (4) @(negedge mclk);
        cs_n = 1'h1;
        repeat (8) @(negedge mclk);
    endtask
endmodule

// ### testbench/fsr_status_read_test.sv
// Self-checking bench for the status read block
`timescale 1ns/1ps
module fsr_status_read_test;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic wp_n = 1'h1;
    fsr_pkg::fsr_live_t live = 8'h9E;
    fsr_pkg::fsr_write_t wr = 10'h000;
    logic cs_n, sclk, si, so_out, so_oe, oe;
    logic [7:0] sb_one, sb_two;
    logic [31:0] rx;
    int n_errors = 0;
    int checked = 0;
    // 100 MHz clock
    always #5 mclk = ~mclk;
    fsr_status_read dut_u (.mclk(mclk), .rst(rst), .cs_n(cs_n),
        .sclk(sclk), .si(si), .wp_n(wp_n), .live(live), .wr(wr),
        .so_out(so_out), .so_oe(so_oe), .status_byte_one(sb_one),
        .status_byte_two(sb_two));
    fsr_host host_u (.mclk(mclk), .so_out(so_out), .so_oe(so_oe),
        .cs_n(cs_n), .sclk(sclk), .si(si));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Expected byte images from live inputs and writable bits
    function automatic logic [7:0] e1(input logic lk);
        return {lk, 1'h0, live.program_error_flag, wp_n,
            live.sw_guard_summary, live.write_latch_on, live.busy_flag};
    endfunction
    function automatic logic [7:0] e2(input logic rs, input logic sl);
        return {3'h0, rs, sl, live.program_paused, live.erase_paused,
            live.busy_flag};
    endfunction
    // Settle time first so the synced pin is current
    task automatic wr_pulse(input logic one, input logic [7:0] d);
        repeat (4) @(negedge mclk);
        wr = {one, ~one, d};
        @(negedge mclk);
        wr = 10'h000;
        repeat (4) @(negedge mclk);
    endtask
    task automatic rd_check(input logic lk, rs, sl, input int from);
        for (int b = from; b < 4; b++) begin
            check(rx[31-8*b -: 8], b[0] ? e2(rs, sl) : e1(lk));
        end
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'h0;
        repeat (6) @(negedge mclk);
        check(sb_one, e1(1'h0));
        check(sb_two, e2(1'h0, 1'h0));
        $display("reset defaults done");
        for (int c = 0; c < 4; c++) begin
            live.sw_guard_summary = c[1:0];
            wp_n = c[0];
            repeat (8) @(negedge mclk);
            check(sb_one, e1(1'h0));
        end
        $display("field mapping done");
        wr_pulse(1'h1, 8'hFF);
        check(sb_one, e1(1'h1));
        wr_pulse(1'h0, 8'hFF);
        check(sb_two, e2(1'h1, 1'h1));
        wr_pulse(1'h0, 8'h08);
        check(sb_two, e2(1'h0, 1'h1));
        host_u.xfer(8'h05, 32, rx, oe);
        check({7'h00, oe}, 8'h01);
        rd_check(1'h1, 1'h0, 1'h1, 0);
        wp_n = 1'h0;
        wr_pulse(1'h1, 8'h00);
        check(sb_one, e1(1'h1));
        wp_n = 1'h1;
        wr_pulse(1'h1, 8'h00);
        check(sb_one, e1(1'h0));
        $display("writes and read done");
        fork
            host_u.xfer(8'h05, 32, rx, oe);
            begin
                repeat (100) @(negedge mclk);
                live.busy_flag = 1'h0;
            end
        join
        rd_check(1'h0, 1'h0, 1'h1, 1);
        $display("busy poll done");
        host_u.xfer(8'hA5, 16, rx, oe);
        check({7'h00, oe}, 8'h00);
        host_u.xfer(8'h05, 12, rx, oe);
        check({7'h00, so_oe}, 8'h00);
        $display("refuse and abort done");
        final_report();
    end
    // Hang guard
    initial begin
        repeat (20000) @(negedge mclk);
        n_errors++;
        final_report();
    end
endmodule
